//--- rtl/sli_pkg.sv
// package for the scanner status indicator block
// assumes a 250 MHz pclk and an apb master for register access
`default_nettype none
package sli_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
  localparam logic [11:0] ADDR_RANGE = 12'h010;
  localparam logic [11:0] ADDR_PING = 12'h014;
  // ---------------------------------------------------------------
  // ctrl fields
  // ---------------------------------------------------------------
  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_LINK_CONN = 1;
  localparam int CTRL_INTERLOCK_EN = 2;
  localparam int CTRL_AUTO_RESTART = 3;
  localparam int CTRL_ACK = 4;
  localparam int CTRL_ERROR = 5;
  localparam int CTRL_CONT_WARN = 6;
  localparam int CTRL_CONT_ERR = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ---------------------------------------------------------------
  // status fields
  // ---------------------------------------------------------------
  localparam int ST_SAFE_ON = 0;
  localparam int ST_STARTUP = 1;
  localparam int ST_PF_OCC = 2;
  localparam int ST_WF_CNT = 3;
  localparam int ST_ILK_READY = 5;
  localparam int ST_PING = 6;
  // ---------------------------------------------------------------
  // interrupt events
  // ---------------------------------------------------------------
  localparam int IRQ_W = 4;
  localparam int EV_SAFE_OFF = 0;
  localparam int EV_SAFE_ON = 1;
  localparam int EV_WARN = 2;
  localparam int EV_STARTUP_DONE = 3;
  localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;
  // ---------------------------------------------------------------
  // ranges in millimetres
  // ---------------------------------------------------------------
  localparam int RANGE_W = 16;
  localparam logic [RANGE_W-1:0] PF_MAX_MM = 16'h0BB8;
  localparam logic [RANGE_W-1:0] WF_MAX_MM = 16'h3A98;
  localparam logic [RANGE_W-1:0] RANGE_RESET = 16'hFFFF;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam longint STARTUP_S = 4;
  localparam longint PING_S = 30;
  localparam longint FLASH_MS = 250;
  localparam longint STARTUP_CYC = STARTUP_S * 1000000 * CLK_MHZ;
  localparam longint PING_CYC = PING_S * 1000000 * CLK_MHZ;
  localparam longint FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 34;
  // ---------------------------------------------------------------
  // led colour codes: bit0 first colour, bit1 second colour
  // ---------------------------------------------------------------
  localparam logic [1:0] COL_OFF = 2'h0;
  localparam logic [1:0] COL_A = 2'h1;
  localparam logic [1:0] COL_B = 2'h2;
  typedef enum logic [1:0] {
    SLI_ST_STARTUP = 2'b00,
    SLI_ST_RUN = 2'b01
  } sli_state_e;
endpackage
`default_nettype wire

//--- rtl/sli_top.sv
// scanner status indicator and field evaluation logic with apb registers
// assumes scan hits arrive from the measurement core on pclk, one per beam
//
// Added by the designer: the APB slave port and the register addresses.
`default_nettype none
// Notes on behaviour
// - five indicators, each colour and pattern
// - led2 flashes while the protective field is occupied, else dark if interlock off or releasing
// - led2 steady when interlock ready for acknowledgment
// - led3 dark with warning fields empty
// - led3 steady with one warning field
// - led3 flashes with both warning fields
// - led4 shows wireless link off, idle, connected
// - ping flashes led4 and led5 green 30 s
// - led5 dark without contamination
// - led5 flashes on contamination warning
// - led5 steady on contamination error, outputs off
// - all leds lit 4 s after power up
// - protective field object turns safe outputs off
// - re-enable when clear, auto or acknowledged
// - warning fields never touch safe outputs
// - protective 3.0 m, warning 15.0 m ranges
module sli_top
  import sli_pkg::*;
#(
  parameter longint STARTUP_CYCLES = sli_pkg::STARTUP_CYC,
  parameter longint PING_CYCLES = sli_pkg::PING_CYC,
  parameter longint FLASH_CYCLES = sli_pkg::FLASH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hit_valid,
  input wire logic [sli_pkg::RANGE_W-1:0] hit_range_mm,
  input wire logic hit_in_pf,
  input wire logic hit_in_wf1,
  input wire logic hit_in_wf2,
  input wire logic scan_end,
  output logic safe_output_pair,
  output logic warn_out1,
  output logic warn_out2,
  output logic [1:0] led1,
  output logic [1:0] led2,
  output logic [1:0] led3,
  output logic [1:0] led4,
  output logic [1:0] led5,
  output logic irq
);
  import sli_pkg::*;

  function automatic logic [1:0] pat(input logic [1:0] col, input logic flash, input logic ph);
    pat = (flash && !ph) ? COL_OFF : col;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sli_state_e st_q, st_d;
  logic [CNT_W-1:0] su_cnt_q, su_cnt_d;
  logic [CNT_W-1:0] ping_cnt_q, ping_cnt_d;
  logic [CNT_W-1:0] fl_cnt_q, fl_cnt_d;
  logic phase_q, phase_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [IRQ_W-1:0] isr_q, isr_d, imask_q, imask_d;
  logic [RANGE_W-1:0] range_q, range_d;
  logic pf_acc_q, pf_acc_d, wf1_acc_q, wf1_acc_d, wf2_acc_q, wf2_acc_d;
  logic pf_occ_q, pf_occ_d, wf1_q, wf1_d, wf2_q, wf2_d;
  logic safe_q, safe_d, blocked_q, blocked_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  logic [1:0] l1_q, l1_d, l2_q, l2_d, l3_q, l3_d, l4_q, l4_d, l5_q, l5_d;
  logic wr, rd, ack_pulse, ping_pulse, pf_hit, wf1_hit, wf2_hit, ilk_ready;
  logic [IRQ_W-1:0] ev;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign ack_pulse = wr && paddr == ADDR_CTRL && pwdata[CTRL_ACK];
  assign ping_pulse = wr && paddr == ADDR_PING;
  // range gates apply before zone membership
  assign pf_hit = hit_valid && hit_in_pf && hit_range_mm <= PF_MAX_MM && hit_range_mm <= range_q;
  assign wf1_hit = hit_valid && hit_in_wf1 && hit_range_mm <= WF_MAX_MM;
  assign wf2_hit = hit_valid && hit_in_wf2 && hit_range_mm <= WF_MAX_MM;
  assign ilk_ready = ctrl_q[CTRL_INTERLOCK_EN] && blocked_q && !pf_occ_q && !ctrl_q[CTRL_CONT_ERR];

  // ---------------------------------------------------------------
  // timers and field evaluation
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    su_cnt_d = su_cnt_q;
    case (st_q)
      SLI_ST_STARTUP: begin
        if (su_cnt_q >= CNT_W'(STARTUP_CYCLES - 1)) begin
          st_d = SLI_ST_RUN;
        end else begin
          su_cnt_d = su_cnt_q + 1'b1;
        end
      end
      SLI_ST_RUN: st_d = SLI_ST_RUN;
      default: st_d = SLI_ST_STARTUP;
    endcase
    ping_cnt_d = ping_pulse ? CNT_W'(PING_CYCLES) : (ping_cnt_q != '0 ? ping_cnt_q - 1'b1 : ping_cnt_q);
    if (fl_cnt_q >= CNT_W'(FLASH_CYCLES - 1)) begin
      fl_cnt_d = '0;
      phase_d = !phase_q;
    end else begin
      fl_cnt_d = fl_cnt_q + 1'b1;
      phase_d = phase_q;
    end
    // occupancy is latched per scan so a sweep cannot flicker the outputs
    pf_acc_d = scan_end ? 1'b0 : (pf_acc_q | pf_hit);
    wf1_acc_d = scan_end ? 1'b0 : (wf1_acc_q | wf1_hit);
    wf2_acc_d = scan_end ? 1'b0 : (wf2_acc_q | wf2_hit);
    pf_occ_d = scan_end ? (pf_acc_q | pf_hit) : (pf_occ_q | pf_hit);
    wf1_d = scan_end ? (wf1_acc_q | wf1_hit) : wf1_q;
    wf2_d = scan_end ? (wf2_acc_q | wf2_hit) : wf2_q;
    safe_d = safe_q;
    blocked_d = blocked_q;
    if (st_q != SLI_ST_RUN || pf_occ_d || ctrl_q[CTRL_CONT_ERR] || ctrl_q[CTRL_ERROR]) begin
      safe_d = 1'b0;
      if (pf_occ_d) begin
        blocked_d = 1'b1;
      end
    end else if (!ctrl_q[CTRL_INTERLOCK_EN] || ctrl_q[CTRL_AUTO_RESTART]) begin
      safe_d = 1'b1;
      blocked_d = 1'b0;
    end else if (!blocked_q || (ack_pulse && ilk_ready)) begin
      safe_d = 1'b1;
      blocked_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SLI_ST_STARTUP;
      su_cnt_q <= '0;
      ping_cnt_q <= '0;
      fl_cnt_q <= '0;
      phase_q <= 1'b0;
      pf_acc_q <= 1'b0;
      wf1_acc_q <= 1'b0;
      wf2_acc_q <= 1'b0;
      pf_occ_q <= 1'b0;
      wf1_q <= 1'b0;
      wf2_q <= 1'b0;
      safe_q <= 1'b0;
      blocked_q <= 1'b1;
    end else begin
      st_q <= st_d;
      su_cnt_q <= su_cnt_d;
      ping_cnt_q <= ping_cnt_d;
      fl_cnt_q <= fl_cnt_d;
      phase_q <= phase_d;
      pf_acc_q <= pf_acc_d;
      wf1_acc_q <= wf1_acc_d;
      wf2_acc_q <= wf2_acc_d;
      pf_occ_q <= pf_occ_d;
      wf1_q <= wf1_d;
      wf2_q <= wf2_d;
      safe_q <= safe_d;
      blocked_q <= blocked_d;
    end
  end

  // ---------------------------------------------------------------
  // indicators
  // ---------------------------------------------------------------
  always_comb begin
    logic pinging;
    pinging = ping_cnt_q != '0;
    if (st_q != SLI_ST_RUN) begin
      // lamp test: red, yellow, blue, green, green
      l1_d = COL_A;
      l2_d = COL_A;
      l3_d = COL_A;
      l4_d = COL_B;
      l5_d = COL_B;
    end else begin
      // led1 bit0 red, bit1 green
      if (ctrl_q[CTRL_ERROR]) begin
        l1_d = pat(COL_A, 1'b1, phase_q);
      end else begin
        l1_d = safe_q ? COL_B : COL_A;
      end
      // led2 yellow
      if (pf_occ_q) begin
        l2_d = pat(COL_A, 1'b1, phase_q);
      end else begin
        l2_d = ilk_ready ? COL_A : COL_OFF;
      end
      // led3 blue
      l3_d = (wf1_q && wf2_q) ? pat(COL_A, 1'b1, phase_q) : ((wf1_q || wf2_q) ? COL_A : COL_OFF);
      // led4 bit0 blue, bit1 green
      if (pinging) begin
        l4_d = pat(COL_B, 1'b1, phase_q);
      end else if (!ctrl_q[CTRL_LINK_EN]) begin
        l4_d = COL_OFF;
      end else begin
        l4_d = pat(COL_A, ctrl_q[CTRL_LINK_CONN], phase_q);
      end
      // led5 bit0 yellow, bit1 green
      if (pinging) begin
        l5_d = pat(COL_B, 1'b1, phase_q);
      end else if (ctrl_q[CTRL_CONT_ERR]) begin
        l5_d = COL_A;
      end else if (ctrl_q[CTRL_CONT_WARN]) begin
        l5_d = pat(COL_A, 1'b1, phase_q);
      end else begin
        l5_d = COL_OFF;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      l1_q <= COL_OFF;
      l2_q <= COL_OFF;
      l3_q <= COL_OFF;
      l4_q <= COL_OFF;
      l5_q <= COL_OFF;
    end else begin
      l1_q <= l1_d;
      l2_q <= l2_d;
      l3_q <= l3_d;
      l4_q <= l4_d;
      l5_q <= l5_d;
    end
  end

  // ---------------------------------------------------------------
  // apb registers and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    range_d = range_q;
    isr_d = isr_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = psel && !penable;
    ev = '0;
    ev[EV_SAFE_OFF] = safe_q && !safe_d;
    ev[EV_SAFE_ON] = !safe_q && safe_d;
    ev[EV_WARN] = scan_end && ((wf1_acc_q | wf1_hit) && !wf1_q || (wf2_acc_q | wf2_hit) && !wf2_q);
    ev[EV_STARTUP_DONE] = st_q == SLI_ST_STARTUP && st_d == SLI_ST_RUN;
    if (wr && pready_q) begin
      case (paddr)
        ADDR_CTRL: ctrl_d = {24'h0, pwdata[7:5], 1'b0, pwdata[3:0]};
        ADDR_IRQ_MASK: imask_d = pwdata[IRQ_W-1:0];
        ADDR_RANGE: range_d = pwdata[RANGE_W-1:0];
        ADDR_PING, ADDR_STAT, ADDR_IRQ_STAT: ctrl_d = ctrl_q;
        default: pslverr_d = 1'b0;
      endcase
    end
    if (psel && !penable) begin
      case (paddr)
        ADDR_CTRL: prdata_d = ctrl_q;
        ADDR_STAT: prdata_d = {25'h0, ping_cnt_q != '0, ilk_ready, wf2_q, wf1_q, pf_occ_q,
                               st_q == SLI_ST_STARTUP, safe_q};
        ADDR_IRQ_STAT: prdata_d = {28'h0, isr_q};
        ADDR_IRQ_MASK: prdata_d = {28'h0, imask_q};
        ADDR_RANGE: prdata_d = {16'h0, range_q};
        ADDR_PING: prdata_d = 32'h0000_0000;
        default: begin
          prdata_d = 32'h0000_0000;
          pslverr_d = 1'b1;
        end
      endcase
    end else if (pready_q) begin
      pslverr_d = pslverr_q;
    end
    // read clears only the bits it reported; an event after the setup edge survives
    if (rd && pready_q && paddr == ADDR_IRQ_STAT) begin
      isr_d = ev | (isr_q & ~prdata_q[IRQ_W-1:0]);
    end else begin
      isr_d = isr_q | ev;
    end
    irq_d = |(isr_d & imask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      imask_q <= MASK_RESET;
      range_q <= RANGE_RESET;
      isr_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      range_q <= range_d;
      isr_q <= isr_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  // warning outputs are plain signals, never gated into safe_q
  assign safe_output_pair = safe_q;
  assign warn_out1 = wf1_q;
  assign warn_out2 = wf2_q;
  assign led1 = l1_q;
  assign led2 = l2_q;
  assign led3 = l3_q;
  assign led4 = l4_q;
  assign led5 = l5_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
endmodule // sli_top
`default_nettype wire

//--- testbench/sli_top_monitor.sv
// checker on the ports of the status indicator block
// assumes a bind from the bench and the same startup length
`default_nettype none
module sli_top_monitor
  import sli_pkg::*;
#(
  parameter longint STARTUP_CYCLES = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic hit_valid,
  input wire logic [sli_pkg::RANGE_W-1:0] hit_range_mm,
  input wire logic hit_in_pf,
  input wire logic safe_output_pair,
  input wire logic warn_out1,
  input wire logic warn_out2,
  input wire logic [1:0] led1,
  input wire logic [1:0] led2,
  input wire logic [1:0] led3,
  input wire logic [1:0] led4,
  input wire logic [1:0] led5
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // cycles since reset, saturating
  // ----------------------------------------
  longint cyc_q;
  longint cyc_d;
  logic run;
  logic lamp;
  always_comb cyc_d = (cyc_q < STARTUP_CYCLES + 8) ? cyc_q + 1 : cyc_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cyc_q <= 0;
    else cyc_q <= cyc_d;
  end
  // margins keep clear of the registered led edges
  assign run = (cyc_q == STARTUP_CYCLES + 8);
  assign lamp = (cyc_q >= 3) && (cyc_q < STARTUP_CYCLES - 1);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wf;
    (run && (warn_out1 ^ warn_out2))[*3];
  endsequence
  property p_pf_off;
    hit_valid && hit_in_pf && hit_range_mm <= PF_MAX_MM |=> !safe_output_pair;
  endproperty
  a_pf_off: assert property (p_pf_off) else $error("safe outputs stayed on after a protective hit");
  property p_far_pf;
    hit_valid && hit_in_pf && hit_range_mm > PF_MAX_MM && safe_output_pair && !psel |=> safe_output_pair;
  endproperty
  a_far_pf: assert property (p_far_pf) else $error("far protective hit switched outputs off");
  property p_wf_only;
    hit_valid && !hit_in_pf && safe_output_pair && !psel |=> safe_output_pair;
  endproperty
  a_wf_only: assert property (p_wf_only) else $error("warning hit switched safe outputs");
  property p_led1_on;
    safe_output_pair[*3] |-> led1 == COL_B;
  endproperty
  a_led1_on: assert property (p_led1_on) else $error("led1 not green with outputs on");
  property p_led3_empty;
    (run && !warn_out1 && !warn_out2)[*3] |-> led3 == COL_OFF;
  endproperty
  a_led3_empty: assert property (p_led3_empty) else $error("led3 lit with warning fields empty");
  property p_led3_one;
    s_one_wf |-> led3 == COL_A;
  endproperty
  a_led3_one: assert property (p_led3_one) else $error("led3 not steady with one warning field");
  property p_lamp;
    lamp |-> led1 == COL_A && led2 == COL_A && led3 == COL_A && led4 == COL_B && led5 == COL_B;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp test pattern wrong during startup");
  property p_ready;
    s_setup |=> pready && psel && penable;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in first access cycle");
endmodule // sli_top_monitor
`default_nettype wire

//--- testbench/sli_led_watch.sv
// operator's eye on one indicator: counts changes, ors colours seen
// assumes clr is pulsed by the bench before each look
`default_nettype none
module sli_led_watch (
  input wire logic pclk,
  input wire logic clr,
  input wire logic [1:0] led,
  output int n_chg,
  output logic [1:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prev;
  // only watches; nothing here feeds back into safety
  always_ff @(posedge pclk) begin
    prev <= led;
    if (clr) begin
      n_chg <= 0;
      seen <= 2'h0;
    end else begin
      if (led != prev) n_chg <= n_chg + 1;
      seen <= seen | led;
    end
  end
endmodule // sli_led_watch
`default_nettype wire

//--- testbench/tb_sli_top.sv
// bench for the status indicator block: apb master, field stimulus, led watchers
// assumes shortened startup, ping and flash counts
`default_nettype none
module tb_sli_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sli_pkg::*;
  localparam longint SC = 40;
  localparam longint PC = 60;
  localparam longint FC = 4;
  logic pclk, presetn, psel, penable, pwrite, hit_valid, hit_in_pf, hit_in_wf1, hit_in_wf2, scan_end, clr;
  logic pready, pslverr, safe_output_pair, warn_out1, warn_out2, irq, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] hit_range_mm;
  logic [1:0] led [1:5];
  logic [1:0] seen [1:5];
  int n_chg [1:5];
  int error_cnt = 0;
  int samples_checked = 0;
  sli_top #(.STARTUP_CYCLES(SC), .PING_CYCLES(PC), .FLASH_CYCLES(FC)) u_sli_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hit_valid(hit_valid), .hit_range_mm(hit_range_mm), .hit_in_pf(hit_in_pf),
    .hit_in_wf1(hit_in_wf1), .hit_in_wf2(hit_in_wf2), .scan_end(scan_end), .safe_output_pair(safe_output_pair),
    .warn_out1(warn_out1), .warn_out2(warn_out2), .led1(led[1]), .led2(led[2]), .led3(led[3]), .led4(led[4]),
    .led5(led[5]), .irq(irq));
  for (genvar i = 1; i <= 5; i++) begin : g_w
    sli_led_watch u_sli_led_watch (.pclk(pclk), .clr(clr), .led(led[i]), .n_chg(n_chg[i]), .seen(seen[i]));
  end
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high at a rising edge; one idle cycle after
  // so that registered side effects are settled when the caller looks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end else begin
      @(posedge pclk);
    end
  endtask
  task automatic scan(input logic pf, input logic w1, input logic w2, input logic [15:0] r);
    hit_valid <= pf | w1 | w2;
    hit_in_pf <= pf;
    hit_in_wf1 <= w1;
    hit_in_wf2 <= w2;
    hit_range_mm <= r;
    @(posedge pclk);
    hit_valid <= 1'b0;
    scan_end <= 1'b1;
    @(posedge pclk);
    scan_end <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // steady: no change in the window; flashing: at least one
  task automatic look(input int i, input logic [1:0] col, input logic fl);
    repeat (4) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (4 * FC) @(posedge pclk);
    @(negedge pclk);
    chk(seen[i], col);
    chk(n_chg[i] != 0, fl);
    @(posedge pclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_start;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    for (int i = 1; i <= 5; i++) chk(led[i], i < 4 ? COL_A : COL_B);
    chk(safe_output_pair, 1'b0);
    repeat (SC) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0008);
    chk(irq, 1'b1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rdv & 32'h8, 32'h8);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rdv & 32'h8, 32'h0);
    chk(irq, 1'b0);
    apb(1'b0, 12'h018, 32'h0);
    chk(errv, 1'b1);
    chk(rdv, 32'h0000_0000);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rdv, 32'h0000_0001);
  endtask
  task automatic t_pf;
    chk(safe_output_pair, 1'b1);
    scan(1'b1, 1'b0, 1'b0, 16'h0BB9);
    chk(safe_output_pair, 1'b1);
    scan(1'b1, 1'b0, 1'b0, 16'h0BB8);
    chk(safe_output_pair, 1'b0);
    look(2, COL_A, 1'b1);
    look(1, COL_A, 1'b0);
    scan(1'b0, 1'b0, 1'b0, 16'h0);
    chk(safe_output_pair, 1'b1);
    look(2, COL_OFF, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    scan(1'b1, 1'b0, 1'b0, 16'h03E8);
    scan(1'b0, 1'b0, 1'b0, 16'h0);
    chk(safe_output_pair, 1'b0);
    look(2, COL_A, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0014);
    repeat (2) @(posedge pclk);
    chk(safe_output_pair, 1'b1);
    look(2, COL_OFF, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_000C);
    scan(1'b1, 1'b0, 1'b0, 16'h03E8);
    chk(safe_output_pair, 1'b0);
    scan(1'b0, 1'b0, 1'b0, 16'h0);
    chk(safe_output_pair, 1'b1);
  endtask
  task automatic t_wf;
    scan(1'b0, 1'b1, 1'b0, 16'h3A99);
    chk(warn_out1, 1'b0);
    scan(1'b0, 1'b1, 1'b0, 16'h3A98);
    chk({warn_out1, safe_output_pair}, 2'h3);
    look(3, COL_A, 1'b0);
    scan(1'b0, 1'b1, 1'b1, 16'h1388);
    chk({warn_out1, warn_out2}, 2'h3);
    look(3, COL_A, 1'b1);
    scan(1'b0, 1'b0, 1'b0, 16'h0);
    look(3, COL_OFF, 1'b0);
  endtask
  task automatic t_ctrl;
    logic [31:0] cv [3] = '{32'h0, 32'h1, 32'h3};
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, ADDR_CTRL, cv[k]);
      look(4, k == 0 ? COL_OFF : COL_A, k == 2);
    end
    apb(1'b1, ADDR_PING, 32'h1);
    look(4, COL_B, 1'b1);
    look(5, COL_B, 1'b1);
    repeat (PC) @(posedge pclk);
    look(4, COL_A, 1'b1);
    look(5, COL_OFF, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0040);
    look(5, COL_A, 1'b1);
    chk(safe_output_pair, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h0000_0080);
    look(5, COL_A, 1'b0);
    chk(safe_output_pair, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0020);
    look(1, COL_A, 1'b1);
  endtask
  initial begin
    {psel, penable, pwrite, hit_valid, hit_in_pf, hit_in_wf1, hit_in_wf2, scan_end, clr} = 9'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hit_range_mm = 16'h0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_start();
    t_pf();
    t_wf();
    t_ctrl();
    end_of_test();
  end
endmodule // tb_sli_top
bind sli_top sli_top_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_sli_top_monitor (.pclk, .presetn, .psel,
  .penable, .pready, .hit_valid, .hit_range_mm, .hit_in_pf, .safe_output_pair, .warn_out1, .warn_out2,
  .led1, .led2, .led3, .led4, .led5);
`default_nettype wire
